/* File: inc/adc_seq_consts.vh */
`ifndef ADC_SEQ_CONSTS_VH
`define ADC_SEQ_CONSTS_VH

// Peripheral clock period in ns (10 MHz)
`define CORE_CLK_PERIOD_NS 100
// Start-up phase length in peripheral cycles
`define STARTUP_CYCLES 2'h2
// Result formatting length in peripheral cycles
`define FORMAT_CYCLES 2'h2
// Fixed part of the sampling phase in converter cycles
`define SAMPLE_BASE_CYCLES 10'h002
// Conversion phase in converter half cycles (13.5 cycles)
`define CONVERT_HALVES 10'h01B
// Warm-up field unit: log2 of converter cycles per field step (16)
`define WARMUP_UNIT_SHIFT 4
// Accumulations above this log2 count are truncated
`define TRUNC_LOG2 3'h4
// Result register width
`define RESULT_WIDTH 16
// Resolution widths
`define RES_BITS_HIGH 5'h0C
`define RES_BITS_LOW 5'h0A
// Saturation limits on the 14-bit signed raw core value
`define SE_MAX 14'h0FFF
`define DIFF_MAX 14'h07FF
`define DIFF_MIN 14'h3800

`endif

/* File: design/adc_result_formatter.v */
`timescale 1ns/100ps
`default_nettype none
`include "adc_seq_consts.vh"

module adc_result_formatter (
    input wire [19:0] i_sum,
    input wire [2:0] i_log2n,
    input wire i_res10,
    input wire i_left_adjust,
    output reg [15:0] o_result
);
    reg [2:0] shift;
    reg [19:0] trunc;
    reg [4:0] width;
    reg [4:0] lshift;

    // Truncate large sums, then place right or left adjusted
    always @* begin
        shift = (i_log2n > `TRUNC_LOG2) ? (i_log2n - `TRUNC_LOG2) : 3'h0;
        trunc = $signed(i_sum) >>> shift;
        width = (i_res10 ? `RES_BITS_LOW : `RES_BITS_HIGH) + {2'h0, i_log2n}
            - {2'h0, shift};
        lshift = 5'h10 - width;
        if (i_left_adjust) begin
            o_result = trunc[15:0] << lshift;
        end else begin
            o_result = trunc[15:0];
        end
    end
endmodule // adc_result_formatter

`default_nettype wire

/* File: design/adc_conversion_sequencer.v */
`timescale 1ns/100ps
`default_nettype none
`include "adc_seq_consts.vh"

module adc_conversion_sequencer (
    input wire i_core_clk,
    input wire i_reset,
    input wire i_enable,
    input wire i_start_write,
    input wire i_event_enable,
    input wire i_start_event,
    input wire i_free_run,
    input wire [2:0] i_clock_divide_select,
    input wire [2:0] i_sample_count_select,
    input wire [3:0] i_sampling_delay_field,
    input wire [7:0] i_sample_length_field,
    input wire [2:0] i_warmup_delay_field,
    input wire i_left_adjust_bit,
    input wire i_differential,
    input wire i_resolution_10bit,
    input wire i_flag_clear,
    input wire [13:0] i_core_value,
    output reg o_start_conversion_bit_q,
    output reg o_result_ready_flag_q,
    output reg o_result_ready_event_q,
    output reg [15:0] o_result_q,
    output reg o_converter_clock_q,
    output reg o_sample_hold_q,
    output reg o_convert_q,
    output reg o_warm_q
);
    localparam [2:0] S_IDLE = 3'h0;
    localparam [2:0] S_STARTUP = 3'h1;
    localparam [2:0] S_SAMPLE = 3'h2;
    localparam [2:0] S_CONVERT = 3'h3;
    localparam [2:0] S_FORMAT = 3'h4;

    // Divide ratio for a select code
    function [8:0] divide_ratio;
        input [2:0] sel;
        begin
            divide_ratio = 9'h002 << sel;
        end
    endfunction

    // Clamp the raw core value and reduce to the chosen resolution
    function [11:0] condition_sample;
        input [13:0] raw;
        input diff;
        input res10;
        reg [13:0] clamped;
        begin
            clamped = raw;
            if (diff) begin
                if ($signed(raw) > $signed(`DIFF_MAX)) begin
                    clamped = `DIFF_MAX;
                end else if ($signed(raw) < $signed(`DIFF_MIN)) begin
                    clamped = `DIFF_MIN;
                end
            end else begin
                if ($signed(raw) < $signed(14'h0000)) begin
                    clamped = 14'h0000;
                end else if ($signed(raw) > $signed(`SE_MAX)) begin
                    clamped = `SE_MAX;
                end
            end
            if (res10) begin
                if (diff) begin
                    condition_sample = {{2{clamped[11]}}, clamped[11:2]};
                end else begin
                    condition_sample = {2'h0, clamped[11:2]};
                end
            end else begin
                condition_sample = clamped[11:0];
            end
        end
    endfunction

    reg [2:0] state_q;
    reg [1:0] step_q;
    reg [9:0] half_q;
    reg [7:0] clock_divide_select_q;
    reg [6:0] index_q;
    reg [19:0] acc_q;
    reg [15:0] warm_cnt_q;
    reg pending_q;
    reg ev_s1_q;
    reg ev_s2_q;
    reg ev_s3_q;
    reg [13:0] core_s1_q;
    reg [13:0] core_s2_q;

    wire [8:0] div = divide_ratio(i_clock_divide_select);
    wire [7:0] div_last = div[7:0] - 8'h01;
    wire [7:0] div_mid = div[8:1] - 8'h01;
    wire active = (state_q == S_SAMPLE) || (state_q == S_CONVERT);
    wire half_tick = active && ((clock_divide_select_q == div_last) || (clock_divide_select_q == div_mid));
    wire ev_rise = ev_s2_q & ~ev_s3_q;
    wire trigger = i_start_write | (i_event_enable & ev_rise);
    wire [9:0] sample_halves = (`SAMPLE_BASE_CYCLES + {6'h00, i_sampling_delay_field}
        + {2'h0, i_sample_length_field}) << 1;
    wire [7:0] count_m1 = (8'h01 << i_sample_count_select) - 8'h01;
    wire last_sample = (index_q == count_m1[6:0]);
    wire [11:0] sample = condition_sample(core_s2_q, i_differential, i_resolution_10bit);
    wire [19:0] sample_ext = i_differential ? {{8{sample[11]}}, sample} : {8'h00, sample};
    wire [19:0] acc_next = acc_q + sample_ext;
    wire [15:0] formatted;
    // Warm-up base of 16 converter cycles per step, kept 16 bits wide before the shift
    wire [15:0] warm_base = {9'h000, i_warmup_delay_field, 4'h0};
    wire [15:0] warm_load = warm_base << ({1'b0, i_clock_divide_select} + 4'h1);

    // Result formatting of the running sum
    adc_result_formatter u_formatter (
        .i_sum(acc_next),
        .i_log2n(i_sample_count_select),
        .i_res10(i_resolution_10bit),
        .i_left_adjust(i_left_adjust_bit),
        .o_result(formatted)
    );

    // Two-stage synchronisers for the event pin and core value
    always @(posedge i_core_clk) begin
        if (i_reset) begin
            ev_s1_q <= 1'b0;
            ev_s2_q <= 1'b0;
            ev_s3_q <= 1'b0;
            core_s1_q <= 14'h0000;
            core_s2_q <= 14'h0000;
        end else begin
            ev_s1_q <= i_start_event;
            ev_s2_q <= ev_s1_q;
            ev_s3_q <= ev_s2_q;
            core_s1_q <= i_core_value;
            core_s2_q <= core_s1_q;
        end
    end

    // Prescaler, only running during sampling and conversion
    always @(posedge i_core_clk) begin
        if (i_reset) begin
            clock_divide_select_q <= 8'h00;
            o_converter_clock_q <= 1'b0;
        end else if (!active) begin
            clock_divide_select_q <= 8'h00;
            o_converter_clock_q <= 1'b0;
        end else begin
            if (clock_divide_select_q == div_last) begin
                clock_divide_select_q <= 8'h00;
            end else begin
                clock_divide_select_q <= clock_divide_select_q + 8'h01;
            end
            o_converter_clock_q <= (clock_divide_select_q < div[8:1]);
        end
    end

    // Warm-up hold-off after enable
    always @(posedge i_core_clk) begin
        if (i_reset) begin
            warm_cnt_q <= 16'h0000;
            o_warm_q <= 1'b0;
        end else if (!i_enable) begin
            warm_cnt_q <= warm_load;
            o_warm_q <= 1'b0;
        end else if (!o_warm_q) begin
            if (warm_cnt_q == 16'h0000) begin
                o_warm_q <= 1'b1;
            end else begin
                warm_cnt_q <= warm_cnt_q - 16'h0001;
            end
        end
    end

    // Result-ready flag, a new result wins over a clear
    always @(posedge i_core_clk) begin
        if (i_reset) begin
            o_result_ready_flag_q <= 1'b0;
        end else if (o_result_ready_event_q) begin
            o_result_ready_flag_q <= 1'b1;
        end else if (i_flag_clear) begin
            o_result_ready_flag_q <= 1'b0;
        end
    end

    // Conversion sequencer
    always @(posedge i_core_clk) begin
        if (i_reset) begin
            state_q <= S_IDLE;
            step_q <= 2'h0;
            half_q <= 10'h000;
            index_q <= 7'h00;
            acc_q <= 20'h00000;
            pending_q <= 1'b0;
            o_start_conversion_bit_q <= 1'b0;
            o_result_ready_event_q <= 1'b0;
            o_result_q <= 16'h0000;
            o_sample_hold_q <= 1'b0;
            o_convert_q <= 1'b0;
        end else if (!i_enable) begin
            state_q <= S_IDLE;
            step_q <= 2'h0;
            half_q <= 10'h000;
            pending_q <= 1'b0;
            o_start_conversion_bit_q <= 1'b0;
            o_result_ready_event_q <= 1'b0;
            o_sample_hold_q <= 1'b0;
            o_convert_q <= 1'b0;
        end else begin
            o_result_ready_event_q <= 1'b0;
            case (state_q)
                S_IDLE: begin
                    if (trigger) begin
                        o_start_conversion_bit_q <= 1'b1;
                    end
                    if ((trigger || pending_q) && o_warm_q) begin
                        state_q <= S_STARTUP;
                        step_q <= 2'h0;
                        index_q <= 7'h00;
                        acc_q <= 20'h00000;
                        pending_q <= 1'b0;
                    end else if (trigger) begin
                        pending_q <= 1'b1;
                    end
                end
                S_STARTUP: begin
                    if (step_q == `STARTUP_CYCLES - 2'h1) begin
                        state_q <= S_SAMPLE;
                        half_q <= 10'h000;
                        o_sample_hold_q <= 1'b1;
                    end else begin
                        step_q <= step_q + 2'h1;
                    end
                end
                S_SAMPLE: begin
                    if (half_tick) begin
                        if (half_q == sample_halves - 10'h001) begin
                            state_q <= S_CONVERT;
                            half_q <= 10'h000;
                            o_sample_hold_q <= 1'b0;
                            o_convert_q <= 1'b1;
                        end else begin
                            half_q <= half_q + 10'h001;
                        end
                    end
                end
                S_CONVERT: begin
                    if (half_tick) begin
                        if (half_q == `CONVERT_HALVES - 10'h001) begin
                            state_q <= S_FORMAT;
                            step_q <= 2'h0;
                            o_convert_q <= 1'b0;
                        end else begin
                            half_q <= half_q + 10'h001;
                        end
                    end
                end
                S_FORMAT: begin
                    if (step_q != `FORMAT_CYCLES - 2'h1) begin
                        step_q <= step_q + 2'h1;
                    end else begin
                        acc_q <= acc_next;
                        if (!last_sample) begin
                            state_q <= S_SAMPLE;
                            index_q <= index_q + 7'h01;
                            half_q <= 10'h000;
                            o_sample_hold_q <= 1'b1;
                        end else begin
                            o_result_q <= formatted;
                            o_result_ready_event_q <= 1'b1;
                            if (i_free_run) begin
                                state_q <= S_STARTUP;
                                step_q <= 2'h0;
                                index_q <= 7'h00;
                                acc_q <= 20'h00000;
                            end else begin
                                state_q <= S_IDLE;
                                o_start_conversion_bit_q <= 1'b0;
                            end
                        end
                    end
                end
                default: begin
                    state_q <= S_IDLE;
                    o_start_conversion_bit_q <= 1'b0;
                    o_sample_hold_q <= 1'b0;
                    o_convert_q <= 1'b0;
                end
            endcase
        end
    end
endmodule // adc_conversion_sequencer

`default_nettype wire

/* File: tb/adc_seq_asserts.sv */
`timescale 1ns/100ps
`default_nettype none
module adc_seq_asserts (
    input wire logic i_core_clk,
    input wire logic i_reset,
    input wire logic i_enable,
    input wire logic i_start_write,
    input wire logic i_free_run,
    input wire logic i_flag_clear,
    input wire logic o_start_conversion_bit_q,
    input wire logic o_result_ready_flag_q,
    input wire logic o_result_ready_event_q,
    input wire logic [15:0] o_result_q,
    input wire logic o_converter_clock_q,
    input wire logic o_sample_hold_q,
    input wire logic o_convert_q,
    input wire logic o_warm_q
);
    // One clock domain, synchronous reset
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_reset);
    // Short aliases
    wire go = o_start_conversion_bit_q;
    wire ev = o_result_ready_event_q;
    wire sh = o_sample_hold_q;
    start_delay_a: assert property (i_start_write && i_enable && o_warm_q && !go && !ev |=> go)
        else $error("start bit not set one cycle after trigger");
    startup_len_a: assert property (disable iff (i_reset || !i_enable) $rose(go) && o_warm_q |-> !sh ##1 !sh ##1 sh)
        else $error("start-up phase not two cycles");
    idle_clock_a: assert property (!go && !$past(go) |-> !o_converter_clock_q)
        else $error("converter clock runs while idle");
    phase_excl_a: assert property (!(sh && o_convert_q))
        else $error("sampling and conversion overlap");
    sample_conv_a: assert property ($fell(sh) && i_enable |-> o_convert_q)
        else $error("conversion does not follow sampling");
    event_pulse_a: assert property (ev |=> !ev)
        else $error("result event longer than one cycle");
    flag_set_a: assert property (ev |=> o_result_ready_flag_q)
        else $error("result flag not set after result");
    flag_clear_a: assert property (i_flag_clear && !ev |=> !o_result_ready_flag_q)
        else $error("result flag not cleared");
    result_hold_a: assert property (!ev |-> $stable(o_result_q))
        else $error("result changed without result event");
    single_done_a: assert property (ev && !i_free_run |-> !go)
        else $error("start bit not cleared on completion");
    free_run_a: assert property (ev && i_free_run && i_enable |-> go)
        else $error("free run did not continue");
    warm_gate_a: assert property ($rose(sh) |-> o_warm_q)
        else $error("conversion started before warm-up");
endmodule // adc_seq_asserts
bind adc_conversion_sequencer adc_seq_asserts u_chk (
    .i_core_clk(i_core_clk), .i_reset(i_reset), .i_enable(i_enable),
    .i_start_write(i_start_write), .i_free_run(i_free_run), .i_flag_clear(i_flag_clear),
    .o_start_conversion_bit_q(o_start_conversion_bit_q),
    .o_result_ready_flag_q(o_result_ready_flag_q),
    .o_result_ready_event_q(o_result_ready_event_q), .o_result_q(o_result_q),
    .o_converter_clock_q(o_converter_clock_q), .o_sample_hold_q(o_sample_hold_q),
    .o_convert_q(o_convert_q), .o_warm_q(o_warm_q)
);
`default_nettype wire

/* File: tb/adc_core_model.sv */
`timescale 1ns/100ps
`default_nettype none
module adc_core_model (
    input wire logic i_core_clk,
    input wire logic i_sample_hold,
    input wire logic [13:0] i_level,
    output logic [13:0] o_core_value
);
    // Track the input while sampling, hold it afterwards
    always @(posedge i_core_clk) begin
        if (i_sample_hold) begin
            o_core_value <= i_level;
        end
    end
endmodule // adc_core_model
`default_nettype wire

/* File: tb/adc_conversion_sequencer_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module adc_conversion_sequencer_tb;
    logic clk = 1'b0;
    logic rst, en, sw, ee, se, fr, la, df, r10, fc;
    logic [2:0] dsel, nsel, wdly;
    logic [3:0] dly;
    logic [7:0] len;
    logic [13:0] level;
    wire [13:0] core;
    wire go, flag, ev, cclk, sh, cv, warm;
    wire [15:0] res;
    integer failures = 0;
    integer num_checks = 0;
    integer c;
    // Compare and count
    `define CHK(n, e, g) begin num_checks = num_checks + 1; if ((g) !== (e)) begin \
        failures = failures + 1; $display("[FAIL] %s exp %0h got %0h", n, e, g); end end
    adc_conversion_sequencer u_dut (
        .i_core_clk(clk), .i_reset(rst), .i_enable(en), .i_start_write(sw),
        .i_event_enable(ee), .i_start_event(se), .i_free_run(fr),
        .i_clock_divide_select(dsel), .i_sample_count_select(nsel),
        .i_sampling_delay_field(dly), .i_sample_length_field(len),
        .i_warmup_delay_field(wdly), .i_left_adjust_bit(la), .i_differential(df),
        .i_resolution_10bit(r10), .i_flag_clear(fc), .i_core_value(core),
        .o_start_conversion_bit_q(go), .o_result_ready_flag_q(flag),
        .o_result_ready_event_q(ev), .o_result_q(res), .o_converter_clock_q(cclk),
        .o_sample_hold_q(sh), .o_convert_q(cv), .o_warm_q(warm)
    );
    adc_core_model u_core (.i_core_clk(clk), .i_sample_hold(sh), .i_level(level),
        .o_core_value(core));
    // 10 MHz peripheral clock
    always #50 clk = ~clk;
    // Verdict and end of run
    task final_report;
        begin
            if (failures == 0 && num_checks > 0) $display("== PASSED ==");
            else $display("== FAILED ==");
            $finish;
        end
    endtask
    // Count edges up to the next result event, start bit must stay set
    task wait_ev(output integer n);
        begin
            n = 0;
            do begin
                @(posedge clk);
                #1 n = n + 1;
                if (ev !== 1'b1) `CHK("busy", 1'b1, go)
            end while (ev !== 1'b1 && n < 20000);
        end
    endtask
    // Bounded wait for warm-up done
    task wait_warm;
        begin
            c = 0;
            while (warm !== 1'b1 && c < 5000) begin
                @(posedge clk);
                #1 c = c + 1;
            end
            `CHK("warm", 1'b1, warm)
        end
    endtask
    // One triggered conversion; f = {differential, 10-bit, left adjust}
    task run_conv(input [2:0] ds, ns, input [3:0] dl, input [7:0] ln, input [2:0] f,
                  input [13:0] v, input [15:0] er, input e);
        integer n, dv, lat;
        begin
            dv = 2 << ds;
            lat = 2 + (1 << ns) * ((2 + dl + ln) * dv + 27 * dv / 2 + 2);
            @(posedge clk);
            {dsel, nsel, dly, len, df, r10, la, level} <= {ds, ns, dl, ln, f, v};
            ee <= e;
            se <= e;
            sw <= !e;
            @(posedge clk);
            sw <= 1'b0;
            if (e) repeat (3) @(posedge clk);
            wait_ev(n);
            if (!e) `CHK("latency", lat, n)
            `CHK("result", er, res)
            @(posedge clk);
            fc <= 1'b1;
            se <= 1'b0;
            #1 `CHK("flag set", 1'b1, flag)
            @(posedge clk);
            fc <= 1'b0;
            #1 `CHK("flag clear", 1'b0, flag)
        end
    endtask
    // Hang guard
    initial begin
        #(30000 * 100);
        failures = failures + 1;
        final_report;
    end
    // Main sequence; dividers stay at 1.25 MHz or faster
    initial begin
        rst = 1'b1;
        {en, sw, ee, se, fr, la, df, r10, fc} = 9'h000;
        {dsel, nsel, dly, len, level} = 32'h0000_0000;
        wdly = 3'h1;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        en <= 1'b1;
        repeat (20) @(posedge clk);
        #1 `CHK("warm early", 1'b0, warm)
        wait_warm;
        run_conv(3'h0, 3'h0, 4'h0, 8'h00, 3'h0, 14'h0123, 16'h0123, 1'h0);
        run_conv(3'h0, 3'h0, 4'h0, 8'h00, 3'h1, 14'h0123, 16'h1230, 1'h0);
        run_conv(3'h0, 3'h0, 4'h0, 8'h00, 3'h2, 14'h0123, 16'h0048, 1'h0);
        run_conv(3'h1, 3'h0, 4'h1, 8'h02, 3'h0, 14'h1388, 16'h0FFF, 1'h0);
        run_conv(3'h2, 3'h0, 4'h3, 8'h00, 3'h0, 14'h3FFB, 16'h0000, 1'h0);
        run_conv(3'h0, 3'h0, 4'h0, 8'h00, 3'h4, 14'h3FFB, 16'hFFFB, 1'h0);
        run_conv(3'h0, 3'h0, 4'h0, 8'h00, 3'h4, 14'h0BB8, 16'h07FF, 1'h0);
        run_conv(3'h0, 3'h0, 4'h0, 8'h00, 3'h4, 14'h3448, 16'hF800, 1'h0);
        run_conv(3'h0, 3'h0, 4'h0, 8'h00, 3'h6, 14'h3FF8, 16'hFFFE, 1'h0);
        run_conv(3'h0, 3'h1, 4'h2, 8'h00, 3'h0, 14'h0123, 16'h0246, 1'h0);
        run_conv(3'h0, 3'h1, 4'h0, 8'h00, 3'h1, 14'h0123, 16'h1230, 1'h0);
        run_conv(3'h0, 3'h5, 4'h0, 8'h00, 3'h0, 14'h0100, 16'h1000, 1'h0);
        // Start event ignored while event input is off, then used
        @(posedge clk);
        se <= 1'b1;
        repeat (10) @(posedge clk);
        #1 `CHK("event off", 1'b0, go)
        @(posedge clk);
        se <= 1'b0;
        run_conv(3'h0, 3'h0, 4'h0, 8'h00, 3'h5, 14'h3FFB, 16'hFFB0, 1'h1);
        // Free running with accumulation of two
        @(posedge clk);
        fr <= 1'b1;
        run_conv(3'h0, 3'h1, 4'h0, 8'h00, 3'h0, 14'h0010, 16'h0020, 1'h0);
        wait_ev(c);
        wait_ev(c);
        `CHK("free interval", 68, c)
        `CHK("free result", 16'h0020, res)
        @(posedge clk);
        fr <= 1'b0;
        wait_ev(c);
        @(posedge clk);
        #1 `CHK("free stop", 1'b0, go)
        // Disable in mid-conversion aborts and idles the prescaler
        @(posedge clk);
        sw <= 1'b1;
        @(posedge clk);
        sw <= 1'b0;
        repeat (10) @(posedge clk);
        en <= 1'b0;
        repeat (2) @(posedge clk);
        #1 `CHK("abort busy", 1'b0, go)
        `CHK("abort clock", 1'b0, cclk)
        @(posedge clk);
        en <= 1'b1;
        wait_warm;
        run_conv(3'h0, 3'h0, 4'h0, 8'h00, 3'h0, 14'h0FFF, 16'h0FFF, 1'h0);
        final_report;
    end
endmodule // adc_conversion_sequencer_tb
`default_nettype wire
